// [inc/pwm_cap_pkg.sv]
// package: register map, field layout and reset values of the pwm/capture timer
package pwm_cap_pkg;
   localparam int AW = 8;
   // fixed control words
   localparam logic [7:0] OFS_PRESCALE = 8'h00;
   localparam logic [7:0] OFS_CLKSEL   = 8'h04;
   localparam logic [7:0] OFS_CTRL     = 8'h08;
   localparam logic [7:0] OFS_DEADZONE = 8'h0c;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h10;
   localparam logic [7:0] OFS_IRQ_IND  = 8'h14;
   localparam logic [7:0] OFS_CAP_FLAG = 8'h18;
   // capture control: group a low/high, group b low/high
   localparam logic [7:0] OFS_CAP_CTRL = 8'h20;
   // per-channel banks, one word per channel 0..7
   localparam logic [7:0] OFS_PERIOD   = 8'h40;
   localparam logic [7:0] OFS_COMPARE  = 8'h60;
   localparam logic [7:0] OFS_COUNT    = 8'h80;
   localparam logic [7:0] OFS_RISE     = 8'ha0;
   localparam logic [7:0] OFS_FALL     = 8'hc0;
   // field positions
   localparam int CTRL_EN_POS     = 0;
   localparam int CTRL_MODE_POS   = 8;
   localparam int CTRL_PAIR_POS   = 16;
   localparam int PRESCALE_W      = 8;
   localparam int CLKSEL_W        = 4;
   localparam int DZ_W            = 8;
   localparam int CAP_EN_POS      = 0;
   localparam int CAP_RISE_IE_POS = 1;
   localparam int CAP_FALL_IE_POS = 2;
   localparam int CAP_HALF_POS    = 16;
   // reset values
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [7:0]  RST_FLAGS = 8'h00;
   // clock divider selections
   localparam logic [2:0] DIV_1  = 3'h0;
   localparam logic [2:0] DIV_2  = 3'h1;
   localparam logic [2:0] DIV_4  = 3'h2;
   localparam logic [2:0] DIV_8  = 3'h3;
   localparam logic [2:0] DIV_16 = 3'h4;
endpackage

// [rtl/pwm_capture_timer.sv]
// pwm generator and capture timer, two groups of four channels, apb slave
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/10ps
module pwm_capture_timer
#(
   parameter int CW = 16,
   parameter int PW = 8
)
(
   input  logic                     pclk,
   input  logic                     presetn,
   input  logic                     ce,
   input  logic                     psel,
   input  logic                     penable,
   input  logic                     pwrite,
   input  logic [pwm_cap_pkg::AW-1:0] paddr,
   input  logic [31:0]              pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  logic [7:0]               cap_in,
   output logic [7:0]               pwm_out,
   output logic [7:0]               pwm_oe,
   output logic                     irq_group_a,
   output logic                     irq_group_b
);
   import pwm_cap_pkg::*;

   logic          acc;
   logic          wr;
   logic [2:0]    bank;
   logic [2:0]    idx;
   logic [31:0]   prescale_r;
   logic [31:0]   clksel_r;
   logic [31:0]   ctrl_r;
   logic [31:0]   deadzone_r;
   logic [31:0]   cap_ctrl_r [4];
   logic [7:0]    irq_en_r;
   logic [7:0]    irq_ind_r;
   logic [7:0]    cap_flag_r;
   logic [7:0]    done_r;
   logic [7:0]    cap_prev_r;
   logic [CW-1:0] period_r   [8];
   logic [CW-1:0] cmp_buf_r  [8];
   logic [CW-1:0] cmp_act_r  [8];
   logic [CW-1:0] cnt_r      [8];
   logic [CW-1:0] rise_r     [8];
   logic [CW-1:0] fall_r     [8];
   logic [3:0]    tick;
   logic [7:0]    zero_evt;
   logic [7:0]    cap_evt;
   logic [7:0]    cap_rise;
   logic [7:0]    cap_fall;
   logic [7:0]    cap_en;
   logic [7:0]    per_wr;
   logic [7:0]    act;
   logic [7:0]    wave;
   logic [7:0]    out_nxt;
   logic [7:0]    oe_nxt;
   logic [7:0]    irq_src;
   logic [7:0]    ind_clr;
   logic [7:0]    flag_clr;
   logic [31:0]   rdata_nxt;
   logic          err_nxt;

   // registers change one edge before the master sees pready
   assign acc  = ce & psel & penable & ~pready;
   assign wr   = acc & pwrite;
   assign bank = paddr[7:5];
   assign idx  = paddr[4:2];

   function automatic logic [3:0] div_last(input logic [2:0] code);
      logic [3:0] r;
      r = 4'h0;
      case (code)
         DIV_2:   r = 4'h1;
         DIV_4:   r = 4'h3;
         DIV_8:   r = 4'h7;
         DIV_16:  r = 4'hf;
         default: r = 4'h0;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // software registers

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prescale_r <= RST_WORD;
         clksel_r   <= RST_WORD;
         ctrl_r     <= RST_WORD;
         deadzone_r <= RST_WORD;
         irq_en_r   <= RST_FLAGS;
      end
      else if (wr)
      begin
         case (paddr)
            OFS_PRESCALE: prescale_r <= pwdata;
            OFS_CLKSEL:   clksel_r   <= pwdata;
            OFS_CTRL:     ctrl_r     <= pwdata;
            OFS_DEADZONE: deadzone_r <= pwdata;
            OFS_IRQ_EN:   irq_en_r   <= pwdata[7:0];
            default:      ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int k = 0; k < 4; k++)
            cap_ctrl_r[k] <= RST_WORD;
      end
      else if (wr && bank == OFS_CAP_CTRL[7:5] && !paddr[4])
      begin
         cap_ctrl_r[paddr[3:2]] <= pwdata;
      end
   end

   // write-one-to-clear; a hardware set in the same cycle wins
   assign ind_clr  = (wr && paddr == OFS_IRQ_IND)  ? pwdata[7:0] : RST_FLAGS;
   assign flag_clr = (wr && paddr == OFS_CAP_FLAG) ? pwdata[7:0] : RST_FLAGS;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_ind_r  <= RST_FLAGS;
         cap_flag_r <= RST_FLAGS;
         cap_prev_r <= RST_FLAGS;
      end
      else
      begin
         irq_ind_r  <= (irq_ind_r & ~ind_clr) | zero_evt;
         cap_flag_r <= (cap_flag_r & ~flag_clr) | cap_evt;
         if (ce)
            cap_prev_r <= cap_in;
      end
   end

   // capture shares the channel interrupt line with the period flag
   assign irq_src = (irq_ind_r & irq_en_r) | cap_flag_r;

   ////////////////////////////////////////////////////////////////////////////////
   // generators: prescaler and divider shared by the two channels of one pair

   for (genvar g = 0; g < 4; g++)
   begin : gen_g
      logic [PW-1:0] pre_r;
      logic [3:0]    div_r;
      logic          wrap;
      assign wrap    = (pre_r == prescale_r[PRESCALE_W*g +: PW]);
      assign tick[g] = ce & wrap & (div_r >= div_last(clksel_r[CLKSEL_W*g +: 3]));
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            pre_r <= '0;
            div_r <= 4'h0;
         end
         else if (ce)
         begin
            if (wrap)
            begin
               pre_r <= '0;
               div_r <= tick[g] ? 4'h0 : div_r + 4'h1;
            end
            else
               pre_r <= pre_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // channels: down-counter, comparator, capture, pair logic and dead zone

   for (genvar c = 0; c < 8; c++)
   begin : gen_c
      localparam int G = c / 2;
      localparam int K = (c / 4) * 2 + (c % 4) / 2;
      localparam int H = c % 2;
      logic [15:0] ccr;
      logic        run;
      logic        auto;
      logic        pair;
      logic        cmp_wr;
      logic        restart;
      logic        src;
      logic [7:0]  dz_len;
      logic [7:0]  dcnt_r;

      assign ccr       = cap_ctrl_r[K][CAP_HALF_POS*H +: 16];
      assign run       = ctrl_r[CTRL_EN_POS + c];
      assign auto      = ctrl_r[CTRL_MODE_POS + c];
      assign pair      = ctrl_r[CTRL_PAIR_POS + G];
      assign cap_en[c] = ccr[CAP_EN_POS];
      assign per_wr[c] = wr & (bank == OFS_PERIOD[7:5]) & (idx == 3'(c));
      assign cmp_wr    = wr & (bank == OFS_COMPARE[7:5]) & (idx == 3'(c));
      // a non-zero period only starts an idle counter; a running one reloads at zero only in auto-reload mode, one-shot stops there
      assign restart   = per_wr[c] & (pwdata[CW-1:0] != '0) & (cnt_r[c] == '0);

      // the pwm counter is the capture timer too
      assign cap_rise[c] = ce & cap_en[c] & cap_in[c] & ~cap_prev_r[c];
      assign cap_fall[c] = ce & cap_en[c] & ~cap_in[c] & cap_prev_r[c];
      assign cap_evt[c]  = (cap_rise[c] & ccr[CAP_RISE_IE_POS])
                         | (cap_fall[c] & ccr[CAP_FALL_IE_POS]);
      // a zero period holds the counter, so no flag repeats
      assign zero_evt[c] = tick[G] & run & ~done_r[c] & (cnt_r[c] == '0)
                         & (period_r[c] != '0);

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            cnt_r[c]     <= '0;
            period_r[c]  <= '0;
            cmp_buf_r[c] <= '0;
            cmp_act_r[c] <= '0;
            done_r[c]    <= 1'b0;
         end
         else if (ce)
         begin
            if (per_wr[c])
               period_r[c] <= pwdata[CW-1:0];
            else if (zero_evt[c] && !auto)
               period_r[c] <= '0;
            if (cmp_wr)
               cmp_buf_r[c] <= pwdata[CW-1:0];
            else if (zero_evt[c] && !auto)
               cmp_buf_r[c] <= '0;
            if (cap_evt[c])
               cnt_r[c] <= period_r[c];
            else if (restart)
               cnt_r[c] <= pwdata[CW-1:0];
            else if (zero_evt[c])
               cnt_r[c] <= auto ? period_r[c] : '0;
            else if (tick[G] && run && !done_r[c] && cnt_r[c] != '0)
               cnt_r[c] <= cnt_r[c] - 1'b1;
            // new duty only at a period boundary
            if (restart || cap_evt[c] || (zero_evt[c] && auto))
               cmp_act_r[c] <= cmp_buf_r[c];
            else if (zero_evt[c])
               cmp_act_r[c] <= '0;
            if (restart)
               done_r[c] <= 1'b0;
            else if (zero_evt[c] && !auto)
               done_r[c] <= 1'b1;
         end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            rise_r[c] <= '0;
            fall_r[c] <= '0;
         end
         else
         begin
            if (cap_rise[c])
               rise_r[c] <= cnt_r[c];
            if (cap_fall[c])
               fall_r[c] <= cnt_r[c];
         end
      end

      // low for period-compare units, then high for compare+1 units
      assign act[c]  = run & ~done_r[c] & ~cap_en[c];
      assign wave[c] = act[c] & (cnt_r[c] <= cmp_act_r[c]);

      if (H == 1)
      begin : gen_odd
         assign src = pair ? (act[c-1] & ~wave[c-1]) : wave[c];
      end
      else
      begin : gen_even
         assign src = wave[c];
      end

      // dead zone counts pclk cycles; only paired outputs are delayed
      assign dz_len = pair ? deadzone_r[DZ_W*G +: 8] : 8'h00;
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            dcnt_r <= 8'h00;
         else if (ce)
         begin
            if (!src)
               dcnt_r <= 8'h00;
            else if (dcnt_r < dz_len)
               dcnt_r <= dcnt_r + 8'h01;
         end
      end
      assign out_nxt[c] = src & (dcnt_r >= dz_len);
      assign oe_nxt[c]  = run & ~cap_en[c];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read decode

   always_comb
   begin
      rdata_nxt = RST_WORD;
      err_nxt   = 1'b0;
      case (bank)
         OFS_PRESCALE[7:5]:
         begin
            case (paddr)
               OFS_PRESCALE: rdata_nxt = prescale_r;
               OFS_CLKSEL:   rdata_nxt = clksel_r;
               OFS_CTRL:     rdata_nxt = ctrl_r;
               OFS_DEADZONE: rdata_nxt = deadzone_r;
               OFS_IRQ_EN:   rdata_nxt = {24'h000000, irq_en_r};
               OFS_IRQ_IND:  rdata_nxt = {24'h000000, irq_ind_r};
               OFS_CAP_FLAG: rdata_nxt = {24'h000000, cap_flag_r};
               default:      err_nxt   = 1'b1;
            endcase
         end
         OFS_CAP_CTRL[7:5]:
         begin
            if (paddr[4])
               err_nxt = 1'b1;
            else
               rdata_nxt = cap_ctrl_r[paddr[3:2]];
         end
         OFS_PERIOD[7:5]:  rdata_nxt = 32'(period_r[idx]);
         OFS_COMPARE[7:5]: rdata_nxt = 32'(cmp_buf_r[idx]);
         OFS_COUNT[7:5]:   rdata_nxt = 32'(cnt_r[idx]);
         OFS_RISE[7:5]:    rdata_nxt = 32'(rise_r[idx]);
         OFS_FALL[7:5]:    rdata_nxt = 32'(fall_r[idx]);
         default:          err_nxt   = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output flops

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata      <= RST_WORD;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         pwm_out     <= RST_FLAGS;
         pwm_oe      <= RST_FLAGS;
         irq_group_a <= 1'b0;
         irq_group_b <= 1'b0;
      end
      else if (ce)
      begin
         pready  <= psel & penable & ~pready;
         pslverr <= acc & err_nxt;
         if (acc && !pwrite)
            prdata <= rdata_nxt;
         pwm_out     <= out_nxt;
         pwm_oe      <= oe_nxt;
         irq_group_a <= |irq_src[3:0];
         irq_group_b <= |irq_src[7:4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_zero0;
      zero_evt[0] && !cap_evt[0] && !per_wr[0];
   endsequence

   // one-shot end on channel 2 with no competing reload
   sequence s_zero2;
      zero_evt[2] && !cap_evt[2] && !per_wr[2];
   endsequence

   sequence s_idle_src;
      ce && irq_src[3:0] == 4'h0;
   endsequence

   a_zero_flag_set:
      assert property (zero_evt[0] |=> irq_ind_r[0])
      else $error("period flag not set at zero");
   a_irq_gated:
      assert property (s_idle_src |=> !irq_group_a)
      else $error("interrupt raised without enabled source");
   a_auto_reload:
      assert property (s_zero0 and ctrl_r[CTRL_MODE_POS] |=> cnt_r[0] == $past(period_r[0]))
      else $error("auto reload did not load period");
   a_oneshot_stop:
      assert property (s_zero2 and !ctrl_r[CTRL_MODE_POS + 2]
                       |=> done_r[2] && cnt_r[2] == '0 && !zero_evt[2])
      else $error("one-shot did not stop at zero");
   a_oneshot_clear:
      assert property (s_zero2 and !ctrl_r[CTRL_MODE_POS + 2]
                       |=> period_r[2] == '0 && cmp_buf_r[2] == '0)
      else $error("one-shot did not clear period and compare");
   a_rise_latch:
      assert property (cap_rise[3] |=> rise_r[3] == $past(cnt_r[3]))
      else $error("rise latch missed counter value");
   a_fall_latch:
      assert property (cap_fall[3] |=> fall_r[3] == $past(cnt_r[3]))
      else $error("fall latch missed counter value");
   a_capture_reload:
      assert property (cap_evt[3] |=> cnt_r[3] == $past(period_r[3]) && cap_flag_r[3])
      else $error("capture did not reload counter");
   a_match_high:
      assert property (ce && wave[0] && !ctrl_r[CTRL_PAIR_POS] |=> pwm_out[0])
      else $error("output not high at compare match");
   a_pair_exclusive:
      assert property (ctrl_r[CTRL_PAIR_POS] && $past(ctrl_r[CTRL_PAIR_POS])
                       |-> !(pwm_out[0] && pwm_out[1]))
      else $error("paired outputs high together");
   a_capture_pin:
      assert property (ce && cap_en[3] |=> !pwm_oe[3])
      else $error("capture pin still driven");
endmodule

// [verification/pwm_and_capture_timer_test.sv]
// self-checking bench for the pwm and capture timer
`timescale 1ns/10ps
module pwm_and_capture_timer_test;
   import pwm_cap_pkg::*;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
   logic        irq_group_a, irq_group_b;
   logic [7:0]  paddr, cap_in, pwm_out, pwm_oe, src;
   logic [31:0] pwdata, prdata, rv, ctrl_v, seed, per, cmp, pre, dz;
   int          mismatches, n_checks, overlap, hi, lo, n;

   pwm_capture_timer #(.CW(16), .PW(8)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_in(cap_in),
      .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq_group_a(irq_group_a),
      .irq_group_b(irq_group_b));
   pwm_stage_model model (.pclk(pclk), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .src(src),
      .cap_in(cap_in), .overlap(overlap));

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd(input logic [31:0] m);
      begin
         seed ^= seed << 13;
         seed ^= seed >> 17;
         seed ^= seed << 5;
         return seed % m;
      end
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         n_checks++;
         if (seen !== exp)
         begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   // request held until pready is sampled high; answer taken at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         for (k = 0; k < 100; k++)
         begin
            @(posedge pclk);
            if (pready === 1'b1)
               break;
         end
         if (k == 100)
            mismatches++;
         rv = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // one whole high phase then one whole low phase, in pclk cycles
   task automatic meas(input int c);
      begin
         for (n = 0; pwm_out[c] !== 1'b0 && n < 9000; n++) @(posedge pclk);
         for (n = 0; pwm_out[c] !== 1'b1 && n < 9000; n++) @(posedge pclk);
         for (hi = 0; pwm_out[c] === 1'b1 && hi < 9000; hi++) @(posedge pclk);
         for (lo = 0; pwm_out[c] === 1'b0 && lo < 9000; lo++) @(posedge pclk);
      end
   endtask

   task results;
      begin
         $display("checks %0d mismatches %0d", n_checks, mismatches);
         if (mismatches == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask

   initial
   begin
      repeat (100000) @(posedge pclk);
      mismatches++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mismatches = 0;
      n_checks = 0;
      seed = 32'ha9bfa8a2;
      {presetn, psel, penable, pwrite, paddr, pwdata, src} = '0;
      ce = 1'b1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_CTRL);
      check(rv, RST_WORD);
      rd(8'h1c);
      check(er, 1'b1);
      check(rv, 32'h0);
      // channel 0 free running, random duty
      per = 8 + rnd(16);
      cmp = rnd(per);
      wr(OFS_COMPARE, cmp);
      wr(OFS_PERIOD, per);
      wr(OFS_IRQ_EN, 32'h1);
      ctrl_v = 32'h101;
      wr(OFS_CTRL, ctrl_v);
      meas(0);
      check(hi, cmp + 1);
      check(lo, per - cmp);
      meas(0);
      check(hi + lo, per + 1);
      rd(OFS_IRQ_IND);
      check(rv[0], 1'b1);
      check(irq_group_a, 1'b1);
      wr(OFS_COMPARE, per);
      repeat (3 * (per + 1)) @(posedge pclk);
      lo = 0;
      repeat (per + 2) @(posedge pclk) lo += (pwm_out[0] !== 1'b1);
      check(lo, 0);
      // every divider ratio with a random prescale on channel 4
      per = 3;
      wr(OFS_COMPARE + 8'h10, 32'h1);
      wr(OFS_PERIOD + 8'h10, per);
      ctrl_v |= 32'h1010;
      wr(OFS_CTRL, ctrl_v);
      for (int s = 0; s < 5; s++)
      begin
         pre = rnd(4);
         wr(OFS_PRESCALE, pre << 16);
         wr(OFS_CLKSEL, s << 8);
         meas(4);
         meas(4);
         check(hi + lo, (pre + 1) * (1 << s) * (per + 1));
      end
      rd(OFS_IRQ_IND);
      check(rv[4], 1'b1);
      check(irq_group_b, 1'b0);
      check(pwm_oe, 8'h11);
      wr(OFS_IRQ_EN, 32'h11);
      repeat (2) @(posedge pclk);
      check(irq_group_b, 1'b1);
      // one-shot on channel 2, then restarted by a new period
      per = 8 + rnd(8);
      cmp = rnd(per);
      ctrl_v |= 32'h4;
      for (int r = 0; r < 2; r++)
      begin
         // enable first so the count starts at the period write, inside the window
         wr(OFS_COMPARE + 8'h08, cmp);
         wr(OFS_CTRL, ctrl_v);
         wr(OFS_PERIOD + 8'h08, per);
         hi = 0;
         repeat (4 * (per + 1)) @(posedge pclk) hi += (pwm_out[2] === 1'b1);
         check(hi, cmp + 1);
         rd(OFS_PERIOD + 8'h08);
         check(rv, 32'h0);
         rd(OFS_COMPARE + 8'h08);
         check(rv, 32'h0);
         rd(OFS_IRQ_IND);
         check(rv[2], 1'b1);
         wr(OFS_IRQ_IND, 32'h4);
      end
      // capture on channel 3, only the falling edge raises the flag
      wr(OFS_IRQ_EN, 32'h0);
      wr(OFS_PERIOD + 8'h0c, 1000);
      ctrl_v |= 32'h808;
      wr(OFS_CTRL, ctrl_v);
      wr(OFS_CAP_CTRL + 8'h04, 32'h5_0000);
      repeat (300) @(posedge pclk);
      check(pwm_oe[3], 1'b0);
      src[3] <= 1'b1;
      repeat (5) @(posedge pclk);
      rd(OFS_RISE + 8'h0c);
      check(rv >= 500 && rv <= 900, 1'b1);
      rd(OFS_CAP_FLAG);
      check(rv[3], 1'b0);
      repeat (300) @(posedge pclk);
      src[3] <= 1'b0;
      repeat (5) @(posedge pclk);
      rd(OFS_FALL + 8'h0c);
      check(rv >= 150 && rv <= 600, 1'b1);
      rd(OFS_COUNT + 8'h0c);
      check(rv >= 980 && rv <= 1000, 1'b1);
      rd(OFS_CAP_FLAG);
      check(rv[3], 1'b1);
      check(irq_group_a, 1'b1);
      wr(OFS_CAP_FLAG, 32'h8);
      rd(OFS_CAP_FLAG);
      check(rv[3], 1'b0);
      // now the rising edge raises the flag and reloads the counter
      wr(OFS_CAP_CTRL + 8'h04, 32'h7_0000);
      src[3] <= 1'b1;
      repeat (5) @(posedge pclk);
      rd(OFS_CAP_FLAG);
      check(rv[3], 1'b1);
      rd(OFS_COUNT + 8'h0c);
      check(rv >= 980 && rv <= 1000, 1'b1);
      // complementary pair 0/1 with a random dead zone
      dz = 1 + rnd(4);
      per = 20;
      cmp = 5 + rnd(6);
      wr(OFS_DEADZONE, dz);
      wr(OFS_COMPARE, cmp);
      wr(OFS_PERIOD, per);
      ctrl_v |= 32'h5_0202;
      wr(OFS_CTRL, ctrl_v);
      repeat (80) @(posedge pclk);
      meas(0);
      check(hi + lo, per + 1);
      for (n = 0; pwm_out[0] === 1'b1 && n < 99; n++) @(posedge pclk);
      for (n = 0; pwm_out[1] !== 1'b1 && n < 99; n++) @(posedge pclk);
      check(n, dz);
      for (hi = 0; pwm_out[1] === 1'b1 && hi < 99; hi++) @(posedge pclk);
      check(hi, per - cmp - dz);
      check(overlap, 0);
      check(pwm_out[5] ^ pwm_out[4], 1'b1);
      results();
   end
endmodule

// [verification/pwm_stage_model.sv]
// model of the power stage and the capture sources at the pwm pins
`timescale 1ns/10ps
module pwm_stage_model
(
   input  logic       pclk,
   input  logic [7:0] pwm_out,
   input  logic [7:0] pwm_oe,
   input  logic [7:0] src,
   output logic [7:0] cap_in,
   output int         overlap
);
   ////////////////////////////////////////////////////////////////////////////
   // a driven pin reads back its own level, a released one follows the source
   assign cap_in = (pwm_oe & pwm_out) | (~pwm_oe & src);
   initial overlap = 0;
   // both switches of one leg on together would short the supply rail
   always @(posedge pclk)
   begin
      for (int p = 0; p < 4; p++)
      begin
         if (pwm_out[2*p] === 1'b1 && pwm_out[2*p+1] === 1'b1)
            overlap <= overlap + 1;
      end
   end
endmodule
